// ===== dv/aout_fieldbus_model.sv
// fieldbus controller model: offers output samples
`timescale 1ns/1ps
module aout_fieldbus_model (
    input wire logic    aclk,     // clock
    output logic [15:0] in_data,  // sample
    output logic [1:0]  in_chan,  // channel
    output logic        in_valid, // offered
    input wire logic    in_ready  // taken
);
    initial begin
        in_data = 16'h0000;
        in_chan = 2'h0;
        in_valid = 1'b0;
    end
    // released lines show the inverse, never the stale word
    task automatic send(input logic [1:0] c, input logic [15:0] d);
        @(posedge aclk);
        in_chan <= c;
        in_data <= d;
        in_valid <= 1'b1;
        do @(posedge aclk); while (!in_ready);
        in_valid <= 1'b0;
        in_data <= ~d;
        in_chan <= ~c;
    endtask : send
endmodule : aout_fieldbus_model

// ===== dv/aout_value_path_asserts.sv
// port assertions for the analog output value path
`timescale 1ns/1ps
module aout_value_path_asserts (
    input wire logic        aclk,      // clock
    input wire logic        aresetn,   // sync reset, low
    input wire logic        awvalid,   // aw valid
    input wire logic        awready,   // aw ready
    input wire logic        wvalid,    // w valid
    input wire logic        wready,    // w ready
    input wire logic [1:0]  bresp,     // b response
    input wire logic        bvalid,    // b valid
    input wire logic        bready,    // b ready
    input wire logic        arvalid,   // ar valid
    input wire logic        arready,   // ar ready
    input wire logic        rvalid,    // r valid
    input wire logic        rready,    // r ready
    input wire logic        in_ready,  // buffer room
    input wire logic [15:0] dac_data,  // converter code
    input wire logic        dac_valid, // code offered
    input wire logic        dac_ready  // code taken
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_IDLE: assert property (disable iff (1'b0)
        !aresetn |=> !bvalid && !rvalid && !dac_valid) else $error("busy");
    AST_DAC_HOLD: assert property (
        dac_valid && !dac_ready |=> dac_valid && $stable(dac_data))
        else $error("converter word dropped");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid &&
        $stable(bresp)) else $error("write response dropped");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid)
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    AST_B_SOON: assert property (
        awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    AST_R_SOON: assert property (arvalid && arready ##1 1'b1 |-> rvalid)
        else $error("read data late");
    AST_B_CODE: assert property (bvalid |-> bresp[0] == 1'b0)
        else $error("bad write response code");
    cover property (dac_valid && !dac_ready);
    cover property (bvalid && bresp == aout_pkg::RESP_SLVERR);
    cover property (!in_ready);
endmodule : aout_value_path_asserts

bind aout_value_path aout_value_path_asserts chk (.aclk, .aresetn,
    .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
    .arvalid, .arready, .rvalid, .rready, .in_ready, .dac_data,
    .dac_valid, .dac_ready);

// ===== dv/aout_value_path_test.sv
// self-checking bench for the analog output value path
`timescale 1ns/1ps
module aout_value_path_test;
    localparam logic [1:0] OK = aout_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = aout_pkg::RESP_SLVERR;
    localparam logic [3:0] CTRL = aout_pkg::REG_CTRL;
    logic        aclk = 1'b0, aresetn = 1'b0, comm_lost = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, dac_ready = 1'b1;
    logic [8:0]  awaddr = 9'h000, araddr = 9'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp, in_chan, dac_chan;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        in_valid, in_ready, dac_valid;
    logic [15:0] in_data, dac_data, v;
    logic [17:0] exp_q[$];
    logic [15:0] pin[4] = '{16'h8000, 16'hFFFF, 16'h8001, 16'hFFFF};
    logic [15:0] pout[4] = '{16'h8000, 16'hFFFF, 16'hFFFF, 16'h0001};
    int          n_mismatch = 0, checks = 0, cyc = 0;

    always #50 aclk = ~aclk;

    aout_value_path #(.RAMP_TICK_CYCLES(500)) dut (.aclk, .aresetn,
        .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hF),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .in_data,
        .in_chan, .in_valid, .in_ready, .comm_lost, .dac_data, .dac_chan,
        .dac_valid, .dac_ready);
    aout_fieldbus_model host (.aclk, .in_data, .in_chan, .in_valid,
        .in_ready);

    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : cmp

    function automatic logic [8:0] ra(input int ch, input logic [3:0] i);
        return 9'(ch * 64 + int'(i) * 4);
    endfunction : ra

    task automatic wr(input logic [8:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        cmp({30'h0, e}, {30'h0, bresp});
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        cmp(e, rdata);
        cmp({30'h0, OK}, {30'h0, rresp});
        rready <= 1'b0;
    endtask : rd

    // a few idle cycles after draining catch unexpected extra words
    task automatic drain();
        repeat (300) begin
            @(posedge aclk);
            if (exp_q.size() == 0) break;
        end
        repeat (4) @(posedge aclk);
    endtask : drain

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    always @(posedge aclk) begin
        cyc++;
        if (aresetn && dac_valid && dac_ready)
            cmp(exp_q.size() != 0 ? {14'h0, exp_q.pop_front()} : 32'hFFFF_FFFF,
                {14'h0, dac_chan, dac_data});
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(11048));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ra(0, CTRL), aout_pkg::RST_CTRL);
        rd(ra(2, aout_pkg::REG_USCALE_GAIN), 32'h0001_0000);
        wr(ra(0, aout_pkg::REG_VCAL_GAIN), 32'h4000, ERR);
        rd(ra(0, aout_pkg::REG_VCAL_GAIN), 32'h1EFA);
        wr(ra(1, aout_pkg::REG_RAW), 32'h1, ERR);
        wr(9'h02C, 32'h1, ERR);
        wr(aout_pkg::ADDR_CODE_WORD, aout_pkg::VENDOR_CODE, OK);
        wr(ra(0, aout_pkg::REG_VCAL_GAIN), 32'h4000, OK);
        $display("register test done");
        for (int p = 0; p < 4; p++) begin
            wr(ra(0, CTRL), 32'h80 | 32'(p << 1), OK);
            exp_q.push_back({2'h0, pout[p]});
            host.send(2'h0, pin[p]);
            drain();
        end
        rd(ra(0, aout_pkg::REG_RAW), 32'h0000_FFFF);
        wr(ra(0, CTRL), 32'h80, OK);
        wr(ra(0, aout_pkg::REG_VCAL_GAIN), 32'h8000, OK);
        exp_q.push_back({2'h0, 16'h7FFF});
        host.send(2'h0, 16'h7000);
        drain();
        wr(ra(1, CTRL), 32'h41, OK);
        wr(ra(1, aout_pkg::REG_UCAL_OFF), 32'h64, OK);
        wr(ra(1, aout_pkg::REG_UCAL_GAIN), 32'h8000, OK);
        wr(ra(1, aout_pkg::REG_USCALE_GAIN), 32'h8000, OK);
        wr(ra(1, aout_pkg::REG_USCALE_OFF), 32'h7, OK);
        exp_q.push_back({2'h1, 16'h03EF});
        host.send(2'h1, 16'h044C);
        drain();
        $display("value path test done");
        // converter stalls while three samples arrive: buffer must fill
        dac_ready <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            v = 16'h2000 + 16'($urandom % 32'h5000);
            exp_q.push_back({2'h1, v - 16'h005D});
            host.send(2'h1, v);
        end
        repeat (2) @(posedge aclk);
        cmp(32'h0, {31'h0, in_ready});
        dac_ready <= 1'b1;
        drain();
        wr(ra(0, aout_pkg::REG_DEFAULT_OUT), 32'h0123, OK);
        wr(ra(1, CTRL), 32'h61, OK);
        wr(ra(2, CTRL), 32'h90, OK);
        wr(ra(2, aout_pkg::REG_DEFAULT_OUT), 32'h0300, OK);
        wr(ra(2, aout_pkg::REG_RAMP_SPEED), 32'h0100, OK);
        // one pass at loss, then one per 500-cycle tick
        for (int k = 1; k < 4; k++) begin
            exp_q.push_back({2'h0, 16'h0123});
            exp_q.push_back({2'h2, 16'(k * 256)});
            exp_q.push_back({2'h3, 16'h0000});
        end
        comm_lost <= 1'b1;
        repeat (1100) @(posedge aclk);
        comm_lost <= 1'b0;
        drain();
        $display("buffer and watchdog test done");
        if (exp_q.size() != 0) n_mismatch++;
        wrap_up();
    end
endmodule : aout_value_path_test

// ===== src/aout_pkg.sv
// constants, register map and encodings of the analog output value path
package aout_pkg;
    localparam int NUM_CH             = 4;
    localparam int CH_W               = 2;
    localparam int ADDR_W             = 9;
    localparam int CLK_PERIOD_NS      = 100;
    localparam int RAMP_TICK_NS       = 1000000;
    localparam int RAMP_TICK_CYCLES   = RAMP_TICK_NS / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH         = 2;

    // per-channel block: byte address = ch * 0x40 + idx * 4
    localparam logic [3:0] REG_CTRL        = 4'h0;
    localparam logic [3:0] REG_USCALE_OFF  = 4'h1;
    localparam logic [3:0] REG_USCALE_GAIN = 4'h2;
    localparam logic [3:0] REG_DEFAULT_OUT = 4'h3;
    localparam logic [3:0] REG_RAMP_SPEED  = 4'h4;
    localparam logic [3:0] REG_UCAL_OFF    = 4'h5;
    localparam logic [3:0] REG_UCAL_GAIN   = 4'h6;
    localparam logic [3:0] REG_VCAL_OFF    = 4'h7;
    localparam logic [3:0] REG_VCAL_GAIN   = 4'h8;
    localparam logic [3:0] REG_RAW         = 4'h9;
    localparam logic [3:0] REG_LAST_OUT    = 4'hA;
    localparam int         CH_REGS         = 9;
    localparam logic [ADDR_W-1:0] ADDR_CODE_WORD = 9'h100;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 9'h104;

    localparam int CTRL_USCALE_EN = 0;
    localparam int CTRL_PRES_LSB  = 1;
    localparam int CTRL_WD_LSB    = 4;
    localparam int CTRL_UCAL_EN   = 6;
    localparam int CTRL_VCAL_EN   = 7;

    localparam logic [31:0] RST_CTRL        = 32'h0000_0080;
    localparam logic [31:0] RST_USCALE_GAIN = 32'h0001_0000;
    localparam logic [31:0] RST_UCAL_GAIN   = 32'h0000_4000;
    localparam logic [31:0] RST_VCAL_GAIN   = 32'h0000_1EFA;
    localparam logic [31:0] MASK_CTRL       = 32'h0000_00FF;
    localparam logic [31:0] MASK_16         = 32'h0000_FFFF;
    // arbitrary value, opens the vendor correction registers
    localparam logic [31:0] VENDOR_CODE     = 32'h0000_A5C3;

    localparam logic [2:0] PRES_SIGNED   = 3'h0;
    localparam logic [2:0] PRES_UNSIGNED = 3'h1;
    localparam logic [2:0] PRES_MAGSIGN  = 3'h2;
    localparam logic [2:0] PRES_ABS      = 3'h3;
    localparam logic [1:0] WD_DEFAULT    = 2'h0;
    localparam logic [1:0] WD_RAMP       = 2'h1;
    localparam logic [1:0] WD_HOLD       = 2'h2;

    localparam int VCAL_SHIFT   = 14;
    localparam int UCAL_SHIFT   = 14;
    localparam int USCALE_SHIFT = 16;
    localparam longint MID_MIN  = -65536;
    localparam longint MID_MAX  = 65535;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : aout_pkg

// ===== src/aout_value_path.sv
// per-channel value path of the analog output: presentation, correction, watchdog
//
// Summary of operation
// - presentation resets to signed two's complement
// - signed: 16-bit two's complement, -32768..32767
// - unsigned: 16-bit value 0..65535
// - magnitude-sign: bit 15 sign, 15-bit magnitude
// - absolute: negative values become positive magnitude
// - watchdog 0: output default value at once
// - watchdog 1: ramp to default, digits per ms
// - watchdog 2: hold last output value
// - vendor stage: (x - offset) * gain >> 14
// - user stage: (y - offset) * gain >> 14
// - scaling: y * gain >> 16 plus offset
// - vendor correction enable resets to true
// - vendor offset, gain writable only with code word
// - each sample runs vendor, user, scaling in order
// - uncorrected value kept readable per channel
// - scaling gain 16 fraction bits, resets unity
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module aout_value_path #(
    parameter int unsigned RAMP_TICK_CYCLES = aout_pkg::RAMP_TICK_CYCLES
) (
    input  wire logic                          aclk,      // system clock
    input  wire logic                          aresetn,   // sync reset, low
    input  wire logic [aout_pkg::ADDR_W-1:0]   awaddr,    // write address
    input  wire logic [2:0]                    awprot,    // unused
    input  wire logic                          awvalid,   // write addr valid
    output logic                               awready,   // write addr ready
    input  wire logic [31:0]                   wdata,     // write data
    input  wire logic [3:0]                    wstrb,     // byte enables
    input  wire logic                          wvalid,    // write data valid
    output logic                               wready,    // write data ready
    output logic [1:0]                         bresp,     // write response
    output logic                               bvalid,    // response valid
    input  wire logic                          bready,    // response ready
    input  wire logic [aout_pkg::ADDR_W-1:0]   araddr,    // read address
    input  wire logic [2:0]                    arprot,    // unused
    input  wire logic                          arvalid,   // read addr valid
    output logic                               arready,   // read addr ready
    output logic [31:0]                        rdata,     // read data
    output logic [1:0]                         rresp,     // read response
    output logic                               rvalid,    // read data valid
    input  wire logic                          rready,    // read data ready
    input  wire logic [15:0]                   in_data,   // process value
    input  wire logic [aout_pkg::CH_W-1:0]     in_chan,   // its channel
    input  wire logic                          in_valid,  // sample offered
    output logic                               in_ready,  // buffer has room
    input  wire logic                          comm_lost, // fieldbus watchdog
    output logic [15:0]                        dac_data,  // converter code
    output logic [aout_pkg::CH_W-1:0]          dac_chan,  // its channel
    output logic                               dac_valid, // code offered
    input  wire logic                          dac_ready  // converter takes
);
    localparam int N = aout_pkg::NUM_CH;

    logic [31:0]        cfg_q   [N][aout_pkg::CH_REGS];
    logic [15:0]        raw_q   [N];
    logic signed [16:0] last_q  [N];
    logic [31:0]        code_q;
    logic               aw_have_q, w_have_q;
    logic [aout_pkg::ADDR_W-1:0] aw_addr_q;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;
    logic [15:0]        fifo_data_q [aout_pkg::FIFO_DEPTH];
    logic [aout_pkg::CH_W-1:0] fifo_chan_q [aout_pkg::FIFO_DEPTH];
    logic               wr_ptr_q, rd_ptr_q;
    logic [1:0]         count_q;
    logic [31:0]        tick_cnt_q;
    logic               lost_q;
    logic [N-1:0]       pend_q;
    logic               pend_q_any_q;

    // ---------------- helpers
    function automatic logic signed [16:0] decode(input logic [15:0] v,
                                                  input logic [2:0] p);
        logic signed [16:0] mag;
        mag = {2'b00, v[14:0]};
        unique case (p)
            aout_pkg::PRES_UNSIGNED: decode = {1'b0, v};
            aout_pkg::PRES_MAGSIGN:  decode = v[15] ? -mag : mag;
            aout_pkg::PRES_ABS:      decode = v[15] ? -{v[15], v}
                                                    : {1'b0, v};
            default:                 decode = {v[15], v};
        endcase
    endfunction : decode

    function automatic logic signed [16:0] sat(input longint v,
                                               input longint lo,
                                               input longint hi);
        longint r;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        sat = 17'(r);
    endfunction : sat

    function automatic longint lo_of(input logic [2:0] p);
        unique case (p)
            aout_pkg::PRES_UNSIGNED, aout_pkg::PRES_ABS: lo_of = 0;
            aout_pkg::PRES_MAGSIGN:                      lo_of = -32767;
            default:                                     lo_of = -32768;
        endcase
    endfunction : lo_of

    function automatic longint hi_of(input logic [2:0] p);
        hi_of = (p == aout_pkg::PRES_UNSIGNED) ? 65535 : 32767;
    endfunction : hi_of

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        for (int b = 0; b < 4; b++) begin
            old[8*b +: 8] = s[b] ? d[8*b +: 8] : old[8*b +: 8];
        end
        merge = old;
    endfunction : merge

    function automatic longint sx16(input logic [31:0] v);
        sx16 = longint'($signed(v[15:0]));
    endfunction : sx16

    function automatic logic [2:0] pres_of(input logic [31:0] c);
        pres_of = c[aout_pkg::CTRL_PRES_LSB +: 3];
    endfunction : pres_of

    // ---------------- register bus
    wire wr_fire = aw_have_q && w_have_q && !bvalid;
    wire [aout_pkg::CH_W-1:0] wr_ch  = aw_addr_q[7:6];
    wire [3:0]                wr_idx = aw_addr_q[5:2];
    wire wr_in_ch = !aw_addr_q[8] && (wr_idx < 4'(aout_pkg::CH_REGS));
    wire vend_reg = (wr_idx == aout_pkg::REG_VCAL_OFF)
                 || (wr_idx == aout_pkg::REG_VCAL_GAIN);
    wire vend_ok  = (code_q == aout_pkg::VENDOR_CODE);
    wire wr_ok    = (wr_in_ch && (!vend_reg || vend_ok))
                 || (aw_addr_q == aout_pkg::ADDR_CODE_WORD);

    assign awready = !aw_have_q;
    assign wready  = !w_have_q;
    assign arready = !rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= aout_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_ok ? aout_pkg::RESP_OKAY : aout_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_q <= '0;
            for (int c = 0; c < N; c++) begin
                for (int r = 0; r < aout_pkg::CH_REGS; r++) begin
                    cfg_q[c][r] <= '0;
                end
                cfg_q[c][aout_pkg::REG_CTRL] <= aout_pkg::RST_CTRL;
                cfg_q[c][aout_pkg::REG_USCALE_GAIN] <=
                    aout_pkg::RST_USCALE_GAIN;
                cfg_q[c][aout_pkg::REG_UCAL_GAIN] <= aout_pkg::RST_UCAL_GAIN;
                cfg_q[c][aout_pkg::REG_VCAL_GAIN] <= aout_pkg::RST_VCAL_GAIN;
            end
        end else if (wr_fire && wr_ok) begin
            if (aw_addr_q[8]) begin
                code_q <= merge(code_q, w_data_q, w_strb_q);
            end else begin
                cfg_q[wr_ch][wr_idx] <=
                    merge(cfg_q[wr_ch][wr_idx], w_data_q, w_strb_q);
            end
        end
    end

    logic [31:0] rd_val;
    logic        rd_hit;
    always_comb begin
        logic [aout_pkg::CH_W-1:0] ch;
        logic [3:0]                idx;
        ch     = araddr[7:6];
        idx    = araddr[5:2];
        rd_val = '0;
        rd_hit = 1'b1;
        if (araddr == aout_pkg::ADDR_CODE_WORD) begin
            rd_val = code_q;
        end else if (araddr == aout_pkg::ADDR_STATUS) begin
            rd_val = {29'b0, count_q, lost_q};
        end else if (araddr[8] || araddr[1:0] != 2'b00) begin
            rd_hit = 1'b0;
        end else if (idx == aout_pkg::REG_RAW) begin
            rd_val = {16'b0, raw_q[ch]};
        end else if (idx == aout_pkg::REG_LAST_OUT) begin
            rd_val = {16'b0, last_q[ch][15:0]};
        end else if (idx == aout_pkg::REG_CTRL) begin
            rd_val = cfg_q[ch][idx] & aout_pkg::MASK_CTRL;
        end else if (idx == aout_pkg::REG_USCALE_GAIN) begin
            rd_val = cfg_q[ch][idx];
        end else if (idx < 4'(aout_pkg::CH_REGS)) begin
            rd_val = cfg_q[ch][idx] & aout_pkg::MASK_16;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= aout_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_val;
            rresp  <= rd_hit ? aout_pkg::RESP_OKAY : aout_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ---------------- two-entry sample buffer
    wire fifo_valid = (count_q != 2'd0);
    wire out_free   = !dac_valid || dac_ready;
    // while the link is down samples are drained and dropped
    wire fifo_pop   = fifo_valid && (lost_q || (out_free && pend_q == '0));
    wire fifo_push  = in_valid && in_ready;
    assign in_ready = (count_q != 2'(aout_pkg::FIFO_DEPTH));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            count_q  <= '0;
            for (int i = 0; i < aout_pkg::FIFO_DEPTH; i++) begin
                fifo_data_q[i] <= '0;
                fifo_chan_q[i] <= '0;
            end
        end else begin
            if (fifo_push) begin
                fifo_data_q[wr_ptr_q] <= in_data;
                fifo_chan_q[wr_ptr_q] <= in_chan;
                wr_ptr_q <= !wr_ptr_q;
            end
            if (fifo_pop) begin
                rd_ptr_q <= !rd_ptr_q;
            end
            count_q <= count_q + 2'(fifo_push) - 2'(fifo_pop);
        end
    end

    // ---------------- correction chain
    wire [15:0]               hd    = fifo_data_q[rd_ptr_q];
    wire [aout_pkg::CH_W-1:0] hc    = fifo_chan_q[rd_ptr_q];
    wire [31:0]               hctrl = cfg_q[hc][aout_pkg::REG_CTRL];
    logic signed [16:0] x_in, y_vend, y_user, y_scal, y_out;
    always_comb begin
        longint t;
        t      = 0;
        x_in   = decode(hd, pres_of(hctrl));
        y_vend = x_in;
        if (hctrl[aout_pkg::CTRL_VCAL_EN]) begin
            t = (longint'(x_in) - sx16(cfg_q[hc][aout_pkg::REG_VCAL_OFF]))
              * longint'(cfg_q[hc][aout_pkg::REG_VCAL_GAIN][15:0]);
            y_vend = sat(t >>> aout_pkg::VCAL_SHIFT,
                         aout_pkg::MID_MIN, aout_pkg::MID_MAX);
        end
        y_user = y_vend;
        if (hctrl[aout_pkg::CTRL_UCAL_EN]) begin
            t = (longint'(y_vend) - sx16(cfg_q[hc][aout_pkg::REG_UCAL_OFF]))
              * longint'(cfg_q[hc][aout_pkg::REG_UCAL_GAIN][15:0]);
            y_user = sat(t >>> aout_pkg::UCAL_SHIFT,
                         aout_pkg::MID_MIN, aout_pkg::MID_MAX);
        end
        y_scal = y_user;
        if (hctrl[aout_pkg::CTRL_USCALE_EN]) begin
            t = longint'(y_user)
              * longint'($signed(cfg_q[hc][aout_pkg::REG_USCALE_GAIN]));
            t = (t >>> aout_pkg::USCALE_SHIFT)
              + sx16(cfg_q[hc][aout_pkg::REG_USCALE_OFF]);
            y_scal = sat(t, aout_pkg::MID_MIN, aout_pkg::MID_MAX);
        end
        y_out = sat(longint'(y_scal), lo_of(pres_of(hctrl)),
                    hi_of(pres_of(hctrl)));
    end

    // ---------------- watchdog behaviour
    wire tick = (tick_cnt_q == RAMP_TICK_CYCLES - 1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= '0;
        end else begin
            // ramp steps are timed from the moment the link drops
            tick_cnt_q <= (tick || (lost_q && !pend_q_any_q))
                        ? '0 : tick_cnt_q + 32'd1;
        end
    end

    logic [aout_pkg::CH_W-1:0] wc;
    always_comb begin
        wc = '0;
        for (int c = N - 1; c >= 0; c--) begin
            if (pend_q[c]) begin
                wc = (aout_pkg::CH_W)'(c);
            end
        end
    end

    wire [31:0] wctrl = cfg_q[wc][aout_pkg::REG_CTRL];
    wire [1:0]  wmode = wctrl[aout_pkg::CTRL_WD_LSB +: 2];
    logic signed [16:0] w_val;
    always_comb begin
        logic signed [16:0] tgt, cur;
        logic signed [17:0] spd, up, dn;
        tgt   = decode(cfg_q[wc][aout_pkg::REG_DEFAULT_OUT][15:0],
                       pres_of(wctrl));
        cur   = last_q[wc];
        spd   = {2'b00, cfg_q[wc][aout_pkg::REG_RAMP_SPEED][15:0]};
        // signed sums: a negative level must not compare as huge
        up    = 18'(cur) + spd;
        dn    = 18'(cur) - spd;
        w_val = cur;
        if (wmode == aout_pkg::WD_DEFAULT) begin
            w_val = tgt;
        end else if (wmode == aout_pkg::WD_RAMP) begin
            if (cur < tgt) begin
                w_val = (up > 18'(tgt)) ? tgt : 17'(up);
            end else if (cur > tgt) begin
                w_val = (dn < 18'(tgt)) ? tgt : 17'(dn);
            end
        end
    end

    // held channels leave the converter alone
    wire w_emit = (pend_q != '0) && out_free
               && (wmode != aout_pkg::WD_HOLD);
    wire w_take = (pend_q != '0) && out_free;
    wire s_emit = fifo_pop && !lost_q;

    // one immediate pass on loss, then one per ramp tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lost_q       <= 1'b0;
            pend_q       <= '0;
            pend_q_any_q <= 1'b0;
        end else begin
            lost_q       <= comm_lost;
            pend_q_any_q <= lost_q;
            if (lost_q && (tick || !pend_q_any_q)) begin
                pend_q <= '1;
            end else if (w_take) begin
                pend_q[wc] <= 1'b0;
            end
        end
    end

    // ---------------- converter output and per-channel state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_valid <= 1'b0;
            dac_data  <= '0;
            dac_chan  <= '0;
            for (int c = 0; c < N; c++) begin
                raw_q[c]  <= '0;
                last_q[c] <= '0;
            end
        end else begin
            if (s_emit) begin
                dac_valid    <= 1'b1;
                dac_data     <= y_out[15:0];
                dac_chan     <= hc;
                raw_q[hc]    <= hd;
                last_q[hc]   <= y_out;
            end else if (w_emit) begin
                dac_valid    <= 1'b1;
                dac_data     <= w_val[15:0];
                dac_chan     <= wc;
                last_q[wc]   <= w_val;
            end else if (dac_ready) begin
                dac_valid    <= 1'b0;
            end
        end
    end
endmodule : aout_value_path
